// File: pcc_bcache.sv
/* Backup cache model: takes every forwarded write at once.
   Assumes one-cycle write pulses on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module pcc_bcache (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire pcc_pkg::pcc_bwr_t bwr_i,
	output logic [7:0] wr_cnt_o
);
	// counts forwarded writes. It never stalls, as the port has no wait.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wr_cnt_o <= 8'h00;
		end else if (bwr_i.valid) begin
			wr_cnt_o <= wr_cnt_o + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: pcc_chk.sv
/* Port checker for the cache control and hit/miss block.
   Assumes it is bound to the top module, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module pcc_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ctl_we_i,
	input wire logic [31:0] ctl_wdata_i,
	input wire logic err_lock_i,
	input wire pcc_pkg::pcc_req_t req_i,
	input wire logic [31:0] ctl_rdata_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic hit_o,
	input wire logic hit_bank_o,
	input wire pcc_pkg::pcc_bwr_t bwr_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic tk, wr, rw, nf;
	// A request counts as taken only when the pipeline is idle.
	assign tk = req_i.valid && !busy_o;
	assign nf = !req_i.fault && !req_i.io_space;
	assign wr = req_i.op inside {pcc_pkg::PCC_OP_WRITE,
		pcc_pkg::PCC_OP_WRITE_UNLOCK};
	assign rw = wr || req_i.op inside {pcc_pkg::PCC_OP_IREAD,
		pcc_pkg::PCC_OP_DREAD, pcc_pkg::PCC_OP_DREAD_LOCK};
	// Two busy cycles, then the result with busy dropped.
	sequence s_res;
		busy_o ##1 busy_o ##1 (done_o && !busy_o);
	endsequence
	resolve_lat_a: assert property (tk |=> s_res)
		else $error("request not resolved in time");
	write_fwd_a: assert property (tk && wr |=> s_res ##0 bwr_o.valid)
		else $error("write not forwarded");
	lock_miss_a: assert property (tk && !req_i.fault &&
		req_i.op == pcc_pkg::PCC_OP_DREAD_LOCK |-> ##3 !hit_o)
		else $error("read lock hit");
	io_miss_a: assert property (tk && req_i.io_space &&
		!req_i.fault |-> ##3 !hit_o) else $error("io space hit");
	fault_hit_a: assert property (tk && req_i.fault && rw |-> ##3 hit_o)
		else $error("faulted access missed");
	err_lock_a: assert property (tk && err_lock_i && !req_i.fault
		|-> ##3 !hit_o) else $error("hit while locked");
	ctl_wr_a: assert property (ctl_we_i ##1 !ctl_we_i |=>
		ctl_rdata_o[4:0] == $past(ctl_wdata_i[4:0], 2))
		else $error("control readback wrong");
	ctl_fix_a: assert property ($past(rst_n_i) |->
		ctl_rdata_o[8:5] == 4'h7) else $error("fixed bits wrong");
	d_off_a: assert property (tk && !ctl_rdata_o[0] && !req_i.fault &&
		req_i.op == pcc_pkg::PCC_OP_DREAD |-> ##3 !hit_o)
		else $error("hit with data stream off");
	fh_bank_a: assert property (tk && nf && !err_lock_i &&
		ctl_rdata_o[2:0] == 3'h5 && req_i.op == pcc_pkg::PCC_OP_DREAD
		|-> ##3 hit_o && hit_bank_o == $past(ctl_rdata_o[3], 3))
		else $error("forced hit bank wrong");
endmodule
`default_nettype wire

// File: pcc_pkg.sv
/*
 * Package for the primary cache control and hit/miss block.
 * Holds control register layout, array geometry, request types and the
 * structs that carry requests and backup-cache writes.
 */
package pcc_pkg;
	localparam int unsigned IDX_W = 7;
	localparam int unsigned TAG_W = 20;
	localparam int unsigned SUB_W = 2;
	localparam int unsigned DEPTH = 128;
	localparam int unsigned ENTRY_W = 4 * 64 + 4 * 8;
	// Physical address field positions.
	localparam int unsigned TAG_LO = 12;
	localparam int unsigned TAG_HI = 31;
	localparam int unsigned IDX_LO = 5;
	localparam int unsigned IDX_HI = 11;
	localparam int unsigned SUB_LO = 3;
	localparam int unsigned SUB_HI = 4;
	// Control register bit positions.
	localparam int unsigned CTL_D_EN = 0;
	localparam int unsigned CTL_I_EN = 1;
	localparam int unsigned CTL_FHIT = 2;
	localparam int unsigned CTL_BSEL = 3;
	localparam int unsigned CTL_P_EN = 4;
	localparam int unsigned CTL_ONES_LO = 5;
	localparam int unsigned CTL_ONES_HI = 7;
	localparam int unsigned CTL_REDUN = 9;
	localparam logic [4:0] CTL_RESET = 5'h00;
	localparam logic [2:0] CTL_ONES = 3'h7;
	localparam logic [0:0] BANK_LEFT = 1'h0;
	localparam logic [0:0] BANK_RIGHT = 1'h1;

	typedef enum logic [2:0] {
		PCC_OP_IREAD = 3'h0,
		PCC_OP_DREAD = 3'h1,
		PCC_OP_DREAD_LOCK = 3'h2,
		PCC_OP_WRITE = 3'h3,
		PCC_OP_WRITE_UNLOCK = 3'h4,
		PCC_OP_IFILL = 3'h5,
		PCC_OP_DFILL = 3'h6,
		PCC_OP_INVAL = 3'h7
	} pcc_op_t;

	typedef struct packed {
		logic valid;
		pcc_op_t op;
		logic [31:0] addr;
		logic io_space;
		logic noncacheable;
		logic fault;
		logic [7:0] byte_en;
		logic [63:0] data;
	} pcc_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [7:0] byte_en;
		logic [63:0] data;
	} pcc_bwr_t;

	// One block of an index: tag, tag parity, quadword valid bits.
	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic tpar;
		logic [3:0] valid;
	} pcc_tag_t;
endpackage

// File: pcc_ram.sv
/*
 * Single-port synchronous memory with registered read data.
 * Assumes one clock; the write and the read of one cycle use one address.
 */
`timescale 1ns/1ps
`default_nettype none
module pcc_ram #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned AW = 7
) (
	input wire logic clk_sys_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic we_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_r [0:(1<<AW)-1];

	// Read returns the old contents on a same-cycle write.
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_r[addr_i] <= wdata_i;
		end
		rdata_o <= mem_r[addr_i];
	end
endmodule
`default_nettype wire

// File: pcc_top.sv
/*
 * Primary cache control register and hit/miss logic for a two-way
 * write-through cache. A request is taken, the addressed index is read in
 * the next cycle, and the result, the array update and the write to the
 * backup cache are issued in the cycle after.
 * Assumes the requester holds off a new request while busy_o is high and
 * that the error-lock bit arrives from the error status logic on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: D-stream accesses miss while data enable clear.
// R2: I-stream reads miss, fills ignored, enable clear.
// R3: Force-hit makes enabled reads and writes hit.
// R4: Bank-select picks right or left forced bank.
// R5: Parity enable clear suppresses all parity errors.
// R6: Bits 7:5 ones, 8 zero, 9 redundancy.
// R7: Error lock acts as both enables clear.
// R8: Invalidate runs unless both disabled or locked.
// R9: Register accesses always accepted.
// R10: Software initialises arrays before enabling.
// R11: Force-hit gives 4K direct-mapped, else 8K two-way.
// R12: I/O space references always miss.
// R13: No tag parity check under force-hit.
// R14: Index by bits 11:5, compare both tags.
// R15: Hit needs match, valid subblock, good parity.
// R16: Read-lock always misses.
// R17: Noncacheable fills forced to miss.
// R18: Faulted references forced to hit, overriding all.
// R19: Force-hit hits selected bank for listed ops.
// R20: Write hit stores masked bytes with parity.
// R21: Write miss leaves arrays; all writes forwarded.
// R22: Writable control bits clear on reset.
module pcc_top (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ctl_we_i,
	input wire logic [31:0] ctl_wdata_i,
	input wire logic err_lock_i,
	input wire logic redundancy_i,
	input wire pcc_pkg::pcc_req_t req_i,
	output logic [31:0] ctl_rdata_o,
	output logic busy_o,
	output logic done_o,
	output logic hit_o,
	output logic hit_bank_o,
	output logic [63:0] rdata_o,
	output logic tag_perr_o,
	output logic [1:0] tag_perr_bank_o,
	output logic data_perr_o,
	output pcc_pkg::pcc_bwr_t bwr_o
);
	logic [4:0] ctl_r;
	logic [1:0] stage_r;
	pcc_pkg::pcc_req_t req_r;
	logic [1:0] tag_we;
	pcc_pkg::pcc_tag_t tag_wdata [2];
	pcc_pkg::pcc_tag_t tag_rd [2];
	logic [1:0] dat_we;
	logic [pcc_pkg::ENTRY_W-1:0] dat_wdata [2];
	logic [pcc_pkg::ENTRY_W-1:0] dat_rd [2];
	logic [pcc_pkg::IDX_W-1:0] idx;
	logic [pcc_pkg::IDX_W-1:0] ram_idx;
	logic [pcc_pkg::SUB_W-1:0] sub;
	logic [pcc_pkg::TAG_W-1:0] atag;
	logic apar;
	logic d_en;
	logic i_en;
	logic f_hit;
	logic bsel;
	logic p_en;
	logic is_i;
	logic is_fill;
	logic is_wr;
	logic is_inval;
	logic stream_en;
	logic force_miss;
	logic force_hit;
	logic [1:0] tmatch;
	logic [1:0] vmatch;
	logic [1:0] tag_hit;
	logic hit;
	logic hbank;
	logic [63:0] qw;
	logic [7:0] qp;
	logic dperr;
	logic [1:0] tperr;

	// R22: Control reset clear.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctl_r <= pcc_pkg::CTL_RESET;
		end else if (ctl_we_i) begin
			ctl_r <= ctl_wdata_i[4:0];
		end
	end

	// R6: Fixed readback bits.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctl_rdata_o <= 32'h0000_0000;
		end else begin
			ctl_rdata_o <= '0;
			ctl_rdata_o[4:0] <= ctl_r;
			ctl_rdata_o[pcc_pkg::CTL_ONES_HI:pcc_pkg::CTL_ONES_LO] <=
				pcc_pkg::CTL_ONES;
			ctl_rdata_o[pcc_pkg::CTL_REDUN] <= redundancy_i;
		end
	end

	// R7: Lock overrides both enables.
	assign d_en = ctl_r[pcc_pkg::CTL_D_EN] & ~err_lock_i;
	assign i_en = ctl_r[pcc_pkg::CTL_I_EN] & ~err_lock_i;
	assign f_hit = ctl_r[pcc_pkg::CTL_FHIT];
	assign bsel = ctl_r[pcc_pkg::CTL_BSEL];
	assign p_en = ctl_r[pcc_pkg::CTL_P_EN];

	// R14: Address field split.
	assign idx = req_r.addr[pcc_pkg::IDX_HI:pcc_pkg::IDX_LO];
	assign sub = req_r.addr[pcc_pkg::SUB_HI:pcc_pkg::SUB_LO];
	assign atag = req_r.addr[pcc_pkg::TAG_HI:pcc_pkg::TAG_LO];
	assign apar = ^atag;
	assign ram_idx = (stage_r == 2'h0) ?
		req_i.addr[pcc_pkg::IDX_HI:pcc_pkg::IDX_LO] : idx;

	// Request pipeline: take, read arrays, resolve. Three cycles per request.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			stage_r <= 2'h0;
			req_r <= '0;
		end else begin
			case (stage_r)
				2'h0: begin
					if (req_i.valid) begin
						req_r <= req_i;
						stage_r <= 2'h1;
					end
				end
				2'h1: stage_r <= 2'h2;
				default: stage_r <= 2'h0;
			endcase
		end
	end

	// Operation classes.
	assign is_i = (req_r.op == pcc_pkg::PCC_OP_IREAD) ||
		(req_r.op == pcc_pkg::PCC_OP_IFILL);
	assign is_fill = (req_r.op == pcc_pkg::PCC_OP_IFILL) ||
		(req_r.op == pcc_pkg::PCC_OP_DFILL);
	assign is_wr = (req_r.op == pcc_pkg::PCC_OP_WRITE) ||
		(req_r.op == pcc_pkg::PCC_OP_WRITE_UNLOCK);
	assign is_inval = (req_r.op == pcc_pkg::PCC_OP_INVAL);
	// R1: Data stream gate.
	// R2: Instruction stream gate.
	assign stream_en = is_i ? i_en : d_en;

	// R12: I/O space misses.
	// R16: Read-lock misses.
	// R17: Noncacheable fills miss.
	assign force_miss = ~stream_en || req_r.io_space ||
		(req_r.op == pcc_pkg::PCC_OP_DREAD_LOCK) ||
		(is_fill && req_r.noncacheable);

	// R3: Enabled force-hit.
	// R19: Force-hit op set.
	// R11: Direct-mapped under force-hit.
	assign force_hit = f_hit && stream_en && !req_r.io_space &&
		!is_fill && (req_r.op != pcc_pkg::PCC_OP_DREAD_LOCK);

	// R14: Compare both tags at once.
	// R15: Match, valid and parity.
	// R13: Tag parity check skipped.
	generate
		for (genvar b = 0; b < 2; b++) begin : g_bank
			assign tmatch[b] = (tag_rd[b].tag == atag);
			assign vmatch[b] = tmatch[b] && tag_rd[b].valid[sub];
			assign tag_hit[b] = vmatch[b] && (tag_rd[b].tpar == apar);
			assign tperr[b] = p_en && !f_hit && vmatch[b] &&
				(tag_rd[b].tpar != apar);
		end
	endgenerate

	// R18: Faults win over all.
	// R4: Forced bank choice.
	always_comb begin
		hit = 1'b0;
		hbank = pcc_pkg::BANK_LEFT;
		if (req_r.fault && !is_fill && !is_inval) begin
			hit = 1'b1;
			hbank = f_hit ? bsel : tag_hit[1];
		end else if (is_inval || force_miss) begin
			hit = 1'b0;
		end else if (force_hit) begin
			hit = 1'b1;
			hbank = bsel;
		end else begin
			hit = |tag_hit;
			hbank = tag_hit[1];
		end
	end

	assign qw = dat_rd[hbank][sub*64 +: 64];
	assign qp = dat_rd[hbank][256 + sub*8 +: 8];

	// R5: Data parity only when enabled.
	always_comb begin
		dperr = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if ((^qw[k*8 +: 8]) != qp[k]) begin
				dperr = 1'b1;
			end
		end
		dperr = dperr && p_en && hit && !is_wr && !req_r.fault;
	end

	// R20: Masked byte store.
	// R21: Miss leaves arrays alone.
	// R8: Invalidate gating.
	// R2: Disabled fill changes nothing.
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			tag_we[b] = 1'b0;
			dat_we[b] = 1'b0;
			tag_wdata[b] = tag_rd[b];
			dat_wdata[b] = dat_rd[b];
		end
		if (stage_r == 2'h2) begin
			if (is_wr && hit && !req_r.fault) begin
				dat_we[hbank] = 1'b1;
				for (int k = 0; k < 8; k++) begin
					if (req_r.byte_en[k]) begin
						dat_wdata[hbank][sub*64 + k*8 +: 8] =
							req_r.data[k*8 +: 8];
						dat_wdata[hbank][256 + sub*8 + k] =
							^req_r.data[k*8 +: 8];
					end
				end
			end else if (is_inval && (d_en || i_en)) begin
				for (int b = 0; b < 2; b++) begin
					if (tmatch[b]) begin
						tag_we[b] = 1'b1;
						tag_wdata[b].valid = 4'h0;
					end
				end
			end
		end
	end

	// Arrays: one tag memory and one data memory per bank.
	generate
		for (genvar b = 0; b < 2; b++) begin : g_mem
			pcc_ram #(
				.WIDTH(pcc_pkg::TAG_W + 5),
				.AW(pcc_pkg::IDX_W)
			) u_tag (
				.clk_sys_i(clk_sys_i),
				.addr_i(ram_idx),
				.we_i(tag_we[b]),
				.wdata_i(tag_wdata[b]),
				.rdata_o(tag_rd[b])
			);
			pcc_ram #(
				.WIDTH(pcc_pkg::ENTRY_W),
				.AW(pcc_pkg::IDX_W)
			) u_dat (
				.clk_sys_i(clk_sys_i),
				.addr_i(ram_idx),
				.we_i(dat_we[b]),
				.wdata_i(dat_wdata[b]),
				.rdata_o(dat_rd[b])
			);
		end
	endgenerate

	// Busy is high in both pipeline cycles after a take.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (stage_r == 2'h0) ? req_i.valid : (stage_r == 2'h1);
		end
	end

	// Result outputs, one-cycle pulse for done and errors.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
			hit_o <= 1'b0;
			hit_bank_o <= 1'b0;
			rdata_o <= 64'h0000_0000_0000_0000;
			tag_perr_o <= 1'b0;
			tag_perr_bank_o <= 2'h0;
			data_perr_o <= 1'b0;
		end else begin
			done_o <= (stage_r == 2'h2);
			hit_o <= (stage_r == 2'h2) && hit;
			hit_bank_o <= hbank;
			rdata_o <= qw;
			// R5: Tag errors need parity enable.
			tag_perr_o <= (stage_r == 2'h2) && !force_miss &&
				!is_inval && !req_r.fault && (|tperr);
			tag_perr_bank_o <= tperr;
			data_perr_o <= (stage_r == 2'h2) && dperr;
		end
	end

	// R21: Every write goes to backup cache.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bwr_o <= '0;
		end else begin
			bwr_o.valid <= (stage_r == 2'h2) && is_wr;
			bwr_o.addr <= req_r.addr;
			bwr_o.byte_en <= req_r.byte_en;
			bwr_o.data <= req_r.data;
		end
	end
endmodule
`default_nettype wire

// File: primary_cache_control_hit_miss_tb.sv
/* Testbench for the cache control block: control writes and requests.
   Assumes the package, design, checker and backup model compile first. */
`timescale 1ns/1ps
`default_nettype none
module primary_cache_control_hit_miss_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ctl_we_i = 1'b0;
	logic [31:0] ctl_wdata_i = 32'h0;
	logic err_lock_i = 1'b0;
	logic redundancy_i = 1'b1;
	pcc_pkg::pcc_req_t req_i = '0;
	logic [31:0] ctl_rdata_o;
	logic busy_o, done_o, hit_o, hit_bank_o, tag_perr_o, data_perr_o;
	logic [63:0] rdata_o, md;
	logic [1:0] tag_perr_bank_o;
	pcc_pkg::pcc_bwr_t bwr_o;
	logic [7:0] wr_cnt;
	logic bk;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	pcc_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.ctl_we_i(ctl_we_i), .ctl_wdata_i(ctl_wdata_i),
		.err_lock_i(err_lock_i), .redundancy_i(redundancy_i), .req_i(req_i),
		.ctl_rdata_o(ctl_rdata_o), .busy_o(busy_o), .done_o(done_o),
		.hit_o(hit_o), .hit_bank_o(hit_bank_o), .rdata_o(rdata_o),
		.tag_perr_o(tag_perr_o), .tag_perr_bank_o(tag_perr_bank_o),
		.data_perr_o(data_perr_o), .bwr_o(bwr_o));
	pcc_bcache bc (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bwr_i(bwr_o),
		.wr_cnt_o(wr_cnt));
	// Free-running 4 ns clock.
	initial forever #2 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Upper write bits are all ones to show they are not stored.
	task automatic ctl_wr(input logic [4:0] v);
		@(posedge clk_sys_i);
		ctl_we_i <= 1'b1;
		ctl_wdata_i <= {27'h7FFFFFF, v};
		@(posedge clk_sys_i);
		ctl_we_i <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("control", {54'h0, redundancy_i, 4'h7, v}, {32'h0, ctl_rdata_o});
	endtask
	// One request to a fixed address; results sampled on a falling edge.
	task automatic rq(input pcc_pkg::pcc_op_t op, input logic eh,
		input logic [2:0] fl = 3'h0, input logic [7:0] be = 8'h00,
		input logic [63:0] d = 64'h0);
		@(posedge clk_sys_i);
		req_i <= '{1'b1, op, 32'h0000_1A48, fl[2], fl[1], fl[0], be, d};
		@(posedge clk_sys_i);
		req_i.valid <= 1'b0;
		repeat (6) begin
			@(negedge clk_sys_i);
			if (done_o === 1'b1) break;
		end
		chk("hit", {62'h0, 1'b1, eh}, {62'h0, done_o, hit_o});
		chk("parity", 64'h0, {62'h0, tag_perr_o, data_perr_o});
		if (eh && !fl[0] && op inside {pcc_pkg::PCC_OP_IREAD,
			pcc_pkg::PCC_OP_DREAD}) begin
			chk("read data", md, rdata_o);
			chk("bank", {63'h0, bk}, {63'h0, hit_bank_o});
		end
		if (op inside {pcc_pkg::PCC_OP_WRITE, pcc_pkg::PCC_OP_WRITE_UNLOCK})
			chk("forward", 64'h1_0000_1A48, {bwr_o.valid, bwr_o.addr});
	endtask
	// Hang guard well above the expected run length.
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk("reset control", 64'h2E0, {32'h0, ctl_rdata_o});
		// each bank is written under force-hit before it is read.
		for (int b = 0; b < 2; b++) begin
			bk = b[0];
			md = bk ? 64'h5555_6666_7777_8888 : 64'h1111_2222_3333_4444;
			ctl_wr({1'b0, bk, 3'h5});
			rq(pcc_pkg::PCC_OP_WRITE, 1'b1, 3'h0, 8'hFF, md);
			rq(pcc_pkg::PCC_OP_WRITE_UNLOCK, 1'b1, 3'h0, 8'h0F,
				64'hAAAA_BBBB_CCCC_DDDD);
			md[31:0] = 32'hCCCC_DDDD;
			rq(pcc_pkg::PCC_OP_DREAD, 1'b1);
		end
		bk = 1'b0;
		md = 64'h1111_2222_CCCC_DDDD;
		ctl_wr(5'h05);
		rq(pcc_pkg::PCC_OP_DREAD, 1'b1);
		rq(pcc_pkg::PCC_OP_IREAD, 1'b0);
		ctl_wr(5'h17);
		rq(pcc_pkg::PCC_OP_IREAD, 1'b1);
		rq(pcc_pkg::PCC_OP_IFILL, 1'b0, 3'h2);
		rq(pcc_pkg::PCC_OP_DFILL, 1'b0, 3'h2);
		rq(pcc_pkg::PCC_OP_DREAD_LOCK, 1'b0);
		rq(pcc_pkg::PCC_OP_DREAD, 1'b0, 3'h4);
		rq(pcc_pkg::PCC_OP_DREAD, 1'b1, 3'h5);
		@(posedge clk_sys_i);
		err_lock_i <= 1'b1;
		rq(pcc_pkg::PCC_OP_DREAD, 1'b0);
		rq(pcc_pkg::PCC_OP_WRITE, 1'b0, 3'h0, 8'hFF, 64'h0);
		@(posedge clk_sys_i);
		err_lock_i <= 1'b0;
		rq(pcc_pkg::PCC_OP_DREAD, 1'b1);
		ctl_wr(5'h04);
		rq(pcc_pkg::PCC_OP_DREAD, 1'b0);
		rq(pcc_pkg::PCC_OP_WRITE, 1'b1, 3'h1, 8'hFF, 64'h0);
		repeat (2) @(negedge clk_sys_i);
		chk("write count", 64'h6, {56'h0, wr_cnt});
		final_report();
	end
endmodule
bind pcc_top pcc_chk chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.ctl_we_i(ctl_we_i), .ctl_wdata_i(ctl_wdata_i), .err_lock_i(err_lock_i),
	.req_i(req_i), .ctl_rdata_o(ctl_rdata_o), .busy_o(busy_o),
	.done_o(done_o), .hit_o(hit_o), .hit_bank_o(hit_bank_o), .bwr_o(bwr_o));
`default_nettype wire
